// ### bas_alu.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "bas_defs.svh"
//----------------------------------------
// Byte datapath: subtract, exclusive-or, nibble exchange
//----------------------------------------
module bas_alu import bas_pkg::*; #(
    parameter int W = `BAS_DATA_W
) (
    input wire logic I_CLK, // Core clock
    input wire logic I_RST_N, // Asynchronous reset, active low
    input wire logic I_VALID, // Operation issued this cycle
    input bas_op_t I_OP, // Operation code
    input wire logic [W-1:0] I_LITERAL, // Eight-bit literal
    input wire logic [W-1:0] I_MEM_RDATA, // Addressed memory byte
    input wire logic [`BAS_ADDR_W-1:0] I_MEM_ADDR, // Memory address of operand
    input wire logic I_DEST, // 0 accumulator, 1 memory
    output logic [W-1:0] O_ACC, // Accumulator
    output bas_flags_t O_FLAGS, // Carry, nibble borrow, zero
    output logic O_MEM_WE, // Memory write pulse
    output logic [`BAS_ADDR_W-1:0] O_MEM_ADDR, // Memory write address
    output logic [W-1:0] O_MEM_WDATA // Memory write data
);
    //----------------------------------------
    // Operand selection and units
    //----------------------------------------
    logic [W-1:0] acc_q;
    bas_flags_t flags_q;
    logic mem_we_q;
    logic [`BAS_ADDR_W-1:0] mem_addr_q;
    logic [W-1:0] mem_wdata_q;
    logic [W-1:0] sub_min;
    logic [W-1:0] sub_diff;
    logic no_borrow;
    logic no_nib_borrow;
    logic [W-1:0] lg_b;
    logic [W-1:0] xor_res;
    logic [W-1:0] swap_res;
    bas_res_t res_d;
    logic to_mem;

    // True for operations whose operand comes from memory
    function automatic logic is_mem_op(input bas_op_t op);
        is_mem_op = (op == BAS_OP_SUBTRACT_FROM_MEMORY) || (op == BAS_OP_NIBBLE_EXCHANGE)
            || (op == BAS_OP_EXCLUSIVE_OR_MEMORY);
    endfunction : is_mem_op

    // True for the five codes that the slice executes
    function automatic logic is_alu_op(input bas_op_t op);
        is_alu_op = is_mem_op(op) || (op == BAS_OP_SUBTRACT_FROM_LITERAL)
            || (op == BAS_OP_EXCLUSIVE_OR_LITERAL);
    endfunction : is_alu_op

    // Byte with its nibbles exchanged, for the checks below
    function automatic logic [7:0] nib_swap(input logic [7:0] b);
        nib_swap = {b[3:0], b[7:4]};
    endfunction : nib_swap

    // Pick literal or memory byte as second operand
    assign sub_min = is_mem_op(I_OP) ? I_MEM_RDATA : I_LITERAL;
    assign lg_b = sub_min;

    bas_sub #(.W(W), .NW(`BAS_NIB_W)) u_sub (
        .i_min(sub_min),
        .i_sub(acc_q),
        .o_diff(sub_diff),
        .o_no_borrow(no_borrow),
        .o_no_nib_borrow(no_nib_borrow)
    );

    bas_logic #(.W(W)) u_logic (
        .i_a(acc_q),
        .i_b(lg_b),
        .o_xor(xor_res),
        .o_swap(swap_res)
    );

    //----------------------------------------
    // Result and flag write enables
    //----------------------------------------
    always_comb begin
        res_d = '0;
        res_d.flags.carry = no_borrow;
        res_d.flags.nibble_borrow_flag = no_nib_borrow;
        unique case (I_OP)
            BAS_OP_SUBTRACT_FROM_LITERAL, BAS_OP_SUBTRACT_FROM_MEMORY: begin
                res_d.value = sub_diff;
                res_d.carry_we = 1'b1;
                res_d.nibble_we = 1'b1;
                res_d.zero_we = 1'b1;
            end
            BAS_OP_EXCLUSIVE_OR_LITERAL, BAS_OP_EXCLUSIVE_OR_MEMORY: begin
                res_d.value = xor_res;
                res_d.zero_we = 1'b1;
            end
            BAS_OP_NIBBLE_EXCHANGE: begin
                res_d.value = swap_res;
            end
            default: begin
                res_d.value = '0;
            end
        endcase
        res_d.flags.zero = (res_d.value == '0);
    end

    // Literal operations always write the accumulator
    assign to_mem = is_mem_op(I_OP) && (I_DEST == `BAS_DEST_MEM);

    //----------------------------------------
    // Accumulator
    //----------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            acc_q <= `BAS_ACC_RST;
        end else if (I_VALID && is_alu_op(I_OP) && !to_mem) begin // Unknown codes leave it alone
            acc_q <= res_d.value;
        end
    end

    //----------------------------------------
    // Status flags
    //----------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flags_q <= '{`BAS_FLAG_RST, `BAS_FLAG_RST, `BAS_FLAG_RST};
        end else if (I_VALID) begin
            if (res_d.carry_we) begin
                flags_q.carry <= res_d.flags.carry;
            end
            if (res_d.nibble_we) begin
                flags_q.nibble_borrow_flag <= res_d.flags.nibble_borrow_flag;
            end
            if (res_d.zero_we) begin
                flags_q.zero <= res_d.flags.zero;
            end
        end
    end

    //----------------------------------------
    // Memory write-back
    //----------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mem_we_q <= 1'b0;
            mem_addr_q <= '0;
            mem_wdata_q <= '0;
        end else begin
            mem_we_q <= I_VALID && to_mem;
            if (I_VALID && to_mem) begin
                mem_addr_q <= I_MEM_ADDR;
                mem_wdata_q <= res_d.value;
            end
        end
    end

    assign O_ACC = acc_q;
    assign O_FLAGS = flags_q;
    assign O_MEM_WE = mem_we_q;
    assign O_MEM_ADDR = mem_addr_q;
    assign O_MEM_WDATA = mem_wdata_q;

    //----------------------------------------
    // Checks
    //----------------------------------------
    // Issue of one operation or of a group, with its destination where it has one; or no issue
    sequence s_sub_issue;
        I_VALID && (I_OP == BAS_OP_SUBTRACT_FROM_LITERAL);
    endsequence

    sequence s_xor_lit_issue;
        I_VALID && (I_OP == BAS_OP_EXCLUSIVE_OR_LITERAL);
    endsequence

    sequence s_lit_issue;
        I_VALID && ((I_OP == BAS_OP_SUBTRACT_FROM_LITERAL) || (I_OP == BAS_OP_EXCLUSIVE_OR_LITERAL));
    endsequence

    sequence s_sub_mem_to_acc;
        I_VALID && (I_OP == BAS_OP_SUBTRACT_FROM_MEMORY) && (I_DEST == `BAS_DEST_ACC);
    endsequence

    sequence s_sub_mem_to_mem;
        I_VALID && (I_OP == BAS_OP_SUBTRACT_FROM_MEMORY) && (I_DEST == `BAS_DEST_MEM);
    endsequence

    sequence s_swap_to_mem;
        I_VALID && (I_OP == BAS_OP_NIBBLE_EXCHANGE) && (I_DEST == `BAS_DEST_MEM);
    endsequence

    sequence s_xor_mem_to_mem;
        I_VALID && (I_OP == BAS_OP_EXCLUSIVE_OR_MEMORY) && (I_DEST == `BAS_DEST_MEM);
    endsequence

    sequence s_logic_issue;
        I_VALID && ((I_OP == BAS_OP_EXCLUSIVE_OR_LITERAL) || (I_OP == BAS_OP_EXCLUSIVE_OR_MEMORY)
            || (I_OP == BAS_OP_NIBBLE_EXCHANGE));
    endsequence

    sequence s_no_issue;
        !I_VALID || (I_OP == BAS_OP_NONE);
    endsequence

    //----------------------------------------
    // Per-operation checks
    //----------------------------------------
    // Literal subtract lands in the accumulator
    a_sublit_acc_value: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_sub_issue |=> O_ACC == $past(I_LITERAL) - $past(O_ACC))
        else $error("literal subtract result wrong");

    // Literal exclusive-or keeps carry and nibble flag
    a_xorlit_flags_kept: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && I_OP == BAS_OP_EXCLUSIVE_OR_LITERAL |=> O_FLAGS.carry == $past(O_FLAGS.carry)
            && O_FLAGS.nibble_borrow_flag == $past(O_FLAGS.nibble_borrow_flag)
            && O_ACC == ($past(O_ACC) ^ $past(I_LITERAL)))
        else $error("literal xor changed wrong state");

    // Memory subtract written back leaves the accumulator
    a_submem_to_mem: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && I_OP == BAS_OP_SUBTRACT_FROM_MEMORY && I_DEST |=> O_MEM_WE
            && O_MEM_WDATA == $past(I_MEM_RDATA) - $past(O_ACC) && $stable(O_ACC))
        else $error("memory subtract write-back wrong");

    // Nibble exchange into the accumulator keeps every flag
    a_swap_flags_kept: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && I_OP == BAS_OP_NIBBLE_EXCHANGE && !I_DEST |=> $stable(O_FLAGS)
            && O_ACC == {$past(I_MEM_RDATA[3:0]), $past(I_MEM_RDATA[7:4])})
        else $error("nibble exchange wrong");

    // Memory exclusive-or into the accumulator writes no memory
    a_xormem_dest_acc: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && I_OP == BAS_OP_EXCLUSIVE_OR_MEMORY && !I_DEST |=> !O_MEM_WE
            && O_ACC == ($past(O_ACC) ^ $past(I_MEM_RDATA)))
        else $error("memory xor to accumulator wrong");

    // Zero flag of a literal subtract
    a_zero_flag_sub: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_sub_issue |=> O_FLAGS.zero == (O_ACC == '0))
        else $error("zero flag mismatch");

    // Carry and nibble flag mean no borrow
    a_carry_no_borrow: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_sub_issue |=> O_FLAGS.carry == ($past(I_LITERAL) >= $past(O_ACC))
            && O_FLAGS.nibble_borrow_flag == ($past(I_LITERAL[3:0]) >= $past(O_ACC[3:0])))
        else $error("borrow flags mismatch");

    //----------------------------------------
    // Destination, write-back and flag checks
    //----------------------------------------
    // A write-back only follows a memory operation aimed at memory
    a_mem_we_pulse: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_MEM_WE |-> $past(I_VALID) && ($past(I_DEST) == `BAS_DEST_MEM) && is_mem_op($past(I_OP)))
        else $error("spurious memory write");

    // Zero flag follows the literal exclusive-or result
    a_xorlit_zero_flag: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_xor_lit_issue |=> O_FLAGS.zero == (O_ACC == '0))
        else $error("literal xor zero flag wrong");

    // Literal operations never touch memory, whatever the select bit
    a_lit_no_write: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_lit_issue |=> !O_MEM_WE)
        else $error("literal operation wrote memory");

    // Memory subtract aimed at the accumulator
    a_submem_to_acc: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_sub_mem_to_acc |=> !O_MEM_WE && O_ACC == $past(I_MEM_RDATA) - $past(O_ACC))
        else $error("memory subtract to accumulator wrong");

    // Borrow and zero flags of a memory subtract written back
    a_submem_flags: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_sub_mem_to_mem |=> O_FLAGS.carry == ($past(I_MEM_RDATA) >= $past(O_ACC))
            && O_FLAGS.nibble_borrow_flag == ($past(I_MEM_RDATA[3:0]) >= $past(O_ACC[3:0]))
            && O_FLAGS.zero == (O_MEM_WDATA == '0))
        else $error("memory subtract flags wrong");

    // Nibble exchange written back leaves accumulator and flags alone
    a_swap_to_mem: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_swap_to_mem |=> O_MEM_WE && O_MEM_WDATA == nib_swap($past(I_MEM_RDATA))
            && $stable(O_FLAGS) && $stable(O_ACC))
        else $error("nibble exchange write-back wrong");

    // Memory exclusive-or written back; only zero follows it
    a_xormem_to_mem: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_xor_mem_to_mem |=> O_MEM_WE && O_MEM_WDATA == ($past(O_ACC) ^ $past(I_MEM_RDATA))
            && $stable(O_ACC) && O_FLAGS.zero == (O_MEM_WDATA == '0))
        else $error("memory xor write-back wrong");

    // Logic operations and the exchange keep carry and nibble flag
    a_carry_kept_logic: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_logic_issue |=> $stable(O_FLAGS.carry) && $stable(O_FLAGS.nibble_borrow_flag))
        else $error("borrow flags changed by logic operation");

    // Write address is the operand address of the issuing operation
    a_wb_addr_copy: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        O_MEM_WE |-> O_MEM_ADDR == $past(I_MEM_ADDR))
        else $error("write-back address wrong");

    // Without an operation nothing changes
    a_idle_state_kept: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        s_no_issue |=> $stable(O_ACC) && $stable(O_FLAGS) && !O_MEM_WE)
        else $error("state changed without an operation");

    // Write address and data stand between write-backs
    a_wb_word_held: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
        !O_MEM_WE |-> $stable(O_MEM_ADDR) && $stable(O_MEM_WDATA))
        else $error("write-back word changed without a write");
endmodule : bas_alu

// ### bas_defs.svh
// What this block does
// - Subtract-from-literal: literal minus accumulator into accumulator; carry, nibble borrow, zero updated.
// - Exclusive-or-literal: accumulator XOR literal into accumulator; only zero flag changes.
// - Subtract-from-memory: memory minus accumulator; select 0 to accumulator, 1 to memory.
// - Nibble-exchange swaps memory nibbles to selected destination; flags untouched.
// - Exclusive-or-memory: accumulator XOR memory to selected destination; only zero flag changes.
`ifndef BAS_DEFS_SVH
`define BAS_DEFS_SVH

//----------------------------------------
// Widths and reset values
//----------------------------------------
`define BAS_DATA_W 8
`define BAS_NIB_W 4
`define BAS_ADDR_W 7
`define BAS_ACC_RST 8'h00
`define BAS_FLAG_RST 1'b0

//----------------------------------------
// Destination select values
//----------------------------------------
`define BAS_DEST_ACC 1'b0
`define BAS_DEST_MEM 1'b1

`endif

// ### bas_logic.sv
`timescale 1ns/1ps
//----------------------------------------
// Exclusive-or and nibble exchange unit
//----------------------------------------
module bas_logic #(
    parameter int W = 8
) (
    input wire logic [W-1:0] i_a, // Accumulator
    input wire logic [W-1:0] i_b, // Literal or memory byte
    output logic [W-1:0] o_xor, // Bitwise exclusive-or
    output logic [W-1:0] o_swap // Nibbles of i_b exchanged
);
    // Combinational results
    assign o_xor = i_a ^ i_b;
    assign o_swap = {i_b[W/2-1:0], i_b[W-1:W/2]};
endmodule : bas_logic

// ### bas_mem_model.sv
`timescale 1ns/1ps
//----------------------------------------
// Data memory on the far side of the slice
//----------------------------------------
module bas_mem_model #(
    parameter int DEPTH = 128
) (
    input wire logic i_clk, // Core clock
    input wire logic [6:0] i_raddr, // Operand address
    output logic [7:0] o_rdata, // Byte at operand address
    input wire logic i_we, // Write-back strobe
    input wire logic [6:0] i_waddr, // Write-back address
    input wire logic [7:0] i_wdata // Write-back data
);
    logic [7:0] mem [DEPTH];
    // Known start contents, mirrored by the bench
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = 8'(i * 37 + 5);
        end
    end
    // Operand byte is read without a clock
    assign o_rdata = mem[i_raddr];
    // Write-back lands at the edge that sees the strobe
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
endmodule : bas_mem_model

// ### bas_pkg.sv
//----------------------------------------
// Types shared by the datapath slice
//----------------------------------------
package bas_pkg;
    typedef enum logic [2:0] {
        BAS_OP_NONE,
        BAS_OP_SUBTRACT_FROM_LITERAL,
        BAS_OP_EXCLUSIVE_OR_LITERAL,
        BAS_OP_SUBTRACT_FROM_MEMORY,
        BAS_OP_NIBBLE_EXCHANGE,
        BAS_OP_EXCLUSIVE_OR_MEMORY
    } bas_op_t;

    // Flag set carried together
    typedef struct packed {
        logic carry;
        logic nibble_borrow_flag;
        logic zero;
    } bas_flags_t;

    // Result of one operation
    typedef struct packed {
        logic [7:0] value;
        bas_flags_t flags;
        logic carry_we;
        logic nibble_we;
        logic zero_we;
    } bas_res_t;
endpackage : bas_pkg

// ### bas_sub.sv
`timescale 1ns/1ps
//----------------------------------------
// Eight-bit subtractor with borrow flags
//----------------------------------------
module bas_sub #(
    parameter int W = 8,
    parameter int NW = 4
) (
    input wire logic [W-1:0] i_min, // Minuend
    input wire logic [W-1:0] i_sub, // Subtrahend
    output logic [W-1:0] o_diff, // Difference
    output logic o_no_borrow, // No borrow out of top bit
    output logic o_no_nib_borrow // No borrow out of low nibble
);
    logic [W:0] full;
    logic [NW:0] low;

    // Two's complement add of inverted subtrahend plus one
    assign full = {1'b0, i_min} + {1'b0, ~i_sub} + {{W{1'b0}}, 1'b1};
    assign low = {1'b0, i_min[NW-1:0]} + {1'b0, ~i_sub[NW-1:0]} + {{NW{1'b0}}, 1'b1};
    assign o_diff = full[W-1:0];
    assign o_no_borrow = full[W];
    assign o_no_nib_borrow = low[NW];
endmodule : bas_sub

// ### byte_alu_subtract_xor_swap_bench.sv
`timescale 1ns/1ps
module byte_alu_subtract_xor_swap_bench import bas_pkg::*; ;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    bas_op_t op = BAS_OP_NONE;
    logic [7:0] lit = 8'h00;
    logic [6:0] addr = 7'h00;
    logic dest = 1'b0;
    logic [7:0] rdata;
    logic [7:0] acc;
    bas_flags_t flags;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [7:0] mem_wdata;
    int error_cnt = 0;
    int checks = 0;
    int m_mem [128];
    int m_acc, m_c, m_dc, m_z, m_we, m_wa, m_wd;
    // Clock at 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    bas_alu i_bas_alu (.I_CLK(clk), .I_RST_N(rst_n), .I_VALID(valid), .I_OP(op), .I_LITERAL(lit),
        .I_MEM_RDATA(rdata), .I_MEM_ADDR(addr), .I_DEST(dest), .O_ACC(acc), .O_FLAGS(flags),
        .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata));
    bas_mem_model i_bas_mem_model (.i_clk(clk), .i_raddr(addr), .o_rdata(rdata), .i_we(mem_we),
        .i_waddr(mem_addr), .i_wdata(mem_wdata));
    //----------------------------------------
    // Compare tasks and verdict
    //----------------------------------------
    task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_byte
    task automatic chk_flags(input logic [2:0] exp, input bas_flags_t got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch flags expected %b seen %b", exp, got);
        end
    endtask : chk_flags
    task automatic chk_bit(input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch mem_we expected %b seen %b", exp, got);
        end
    endtask : chk_bit
    task automatic report_and_stop;
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    //----------------------------------------
    // Issue one op, check the previous one, model the new one
    //----------------------------------------
    task automatic step(input int v, input int o, input int k, input int a, input int d);
        int b;
        int r;
        @(posedge clk);
        valid <= v[0];
        op <= bas_op_t'(o[2:0]);
        lit <= 8'(k);
        addr <= 7'(a);
        dest <= d[0];
        #1;
        chk_byte("acc", 8'(m_acc), acc);
        chk_flags({m_c[0], m_dc[0], m_z[0]}, flags);
        chk_bit(m_we[0], mem_we);
        if (m_we == 1) begin
            chk_byte("mem_addr", 8'(m_wa), {1'b0, mem_addr});
            chk_byte("mem_wdata", 8'(m_wd), mem_wdata);
        end
        // The op reads memory before the previous write-back lands
        b = (o >= 3) ? m_mem[a] : k;
        if (m_we == 1) begin
            m_mem[m_wa] = m_wd;
        end
        m_we = 0;
        if (v == 1 && o >= 1) begin
            case (o)
                1, 3: begin
                    r = (b - m_acc) & 255;
                    m_c = (b >= m_acc);
                    m_dc = ((b & 15) >= (m_acc & 15));
                end
                2, 5: r = m_acc ^ b;
                default: r = ((b & 15) << 4) | (b >> 4);
            endcase
            if (o != 4) begin
                m_z = (r == 0);
            end
            if (o >= 3 && d == 1) begin
                m_we = 1;
                m_wa = a;
                m_wd = r;
            end else begin
                m_acc = r;
            end
        end
    endtask : step
    // Main sequence
    initial begin
        void'($urandom(32'h266def6e));
        for (int i = 0; i < 128; i++) begin
            m_mem[i] = (i * 37 + 5) & 255;
        end
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        step(1, 1, 0, 0, 0);
        step(1, 3, 0, 9, 1);
        step(1, 3, 0, 9, 1);
        step(1, 4, 0, 9, 0);
        step(1, 5, 0, 9, 1);
        step(1, 2, 255, 0, 0);
        for (int n = 0; n < 2000; n++) begin
            step(int'($urandom_range(0, 7) != 0), $urandom_range(0, 5), $urandom_range(0, 255),
                $urandom_range(0, (n < 1000) ? 127 : 3), $urandom_range(0, 1));
            if (n == 1000) begin
                step(0, 0, 0, 0, 0);
                @(posedge clk);
                rst_n <= 1'b0;
                m_acc = 0;
                m_c = 0;
                m_dc = 0;
                m_z = 0;
                repeat (3) @(posedge clk);
                rst_n <= 1'b1;
            end
        end
        step(0, 0, 0, 0, 0);
        report_and_stop();
    end
    // Watchdog against a hang
    initial begin
        #50000;
        error_cnt++;
        report_and_stop();
    end
endmodule : byte_alu_subtract_xor_swap_bench
